// ===== inc/idp_pkg.sv
`default_nettype none

package idp_pkg;

  // ==========================================================================
  // Register map and field layout
  // ==========================================================================
  localparam int unsigned ADDR_W        = 2;
  localparam int unsigned DATA_W        = 8;
  localparam logic [1:0]  OFF_OUT_DATA  = 2'h0;
  localparam logic [1:0]  OFF_IN_DATA   = 2'h1;
  localparam logic [1:0]  OFF_DIR_CTRL  = 2'h3;
  localparam logic [7:0]  CTRL_WORD_STD = 8'h82;
  localparam logic [7:0]  CTRL_CARE     = 8'hF6;
  localparam int unsigned CTRL_BIT_MODE = 7;
  localparam int unsigned CTRL_BIT_PB   = 1;
  localparam logic [7:0]  OUT_RESET     = 8'h00;
  localparam logic [7:0]  RD_ZERO       = 8'h00;

  // ==========================================================================
  // Host access carrier
  // ==========================================================================
  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [1:0]       addr;
    logic [7:0]       wdata;
  } idp_req_t;

  typedef enum logic {IDP_DIR_IN, IDP_DIR_OUT} idp_dir_t;

endpackage

`default_nettype wire

// ===== hw/idp_port.sv
// Contract
// R1: Write offset 0 latches eight output bits.
// R2: Reading offset 0 returns output line states.
// R3: Offset 1 read returns input lines.
// R4: Writing offset 3 sets port directions.
// R5: Host writes control bits per fixed pattern.
// R6: Host writes 0x82 before data transfers.
// R7: Output bit n drives output line n.
// R8: Input bit n set when line high.
// R9: Control write resets other ports' state.
// R10: Undriven inputs read as zero.
// R11: Block never raises an interrupt.
// R12: Both ports default to input direction.
// R13: Synchronous reset clears latch, inputs direction.
// R14: Ignore input writes; control reads zero.
`timescale 1ns/1ps
`default_nettype none

module idp_port #(
  parameter int unsigned DATA_W = idp_pkg::DATA_W,  // Port width; the carrier fixes it.
  parameter int unsigned ADDR_W = idp_pkg::ADDR_W   // Offset width; the carrier fixes it.
) (
  input  wire logic              ref_clk,        // Host bus clock, 25 MHz.
  input  wire logic              rst_b,          // Asynchronous reset, active low.
  input  wire logic              sync_clr,       // Synchronous board reset, active high.
  input  wire idp_pkg::idp_req_t host_req,       // Host access, one cycle per strobe.
  output logic [7:0]             host_rdata,     // Read data, valid one cycle after rd.
  output logic [7:0]             isolated_output_line, // Output port lines.
  output logic                   output_enable,  // High while port drives its lines.
  input  wire logic [7:0]        isolated_input_line,  // Asynchronous input pins.
  output logic                   host_irq        // Always low.
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The host carrier and the pin ports are eight bits wide and the offset two,
  // so the logic cannot serve any other width.
  if (DATA_W != 8)
  begin : g_bad_width
    $error("idp_port serves an 8-bit data width only");
  end
  if (ADDR_W != 2)
  begin : g_bad_addr
    $error("idp_port decodes a 2-bit offset only");
  end

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  // Undriven inputs are expected to be pulled low on the board, so they read 0.
  logic [7:0] in_meta_q, in_sync_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_meta_q <= 8'h00;
      in_sync_q <= 8'h00;
    end
    else
    begin
      in_meta_q <= isolated_input_line;
      in_sync_q <= in_meta_q; // see R10
    end
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [7:0]       out_q, out_d;
  idp_pkg::idp_dir_t dir_a_q, dir_a_d, dir_b_q, dir_b_d;
  logic [7:0]       rdata_q, rdata_d;
  logic [7:0]       line_q, line_d;
  logic             oe_q, oe_d;

  function automatic logic hit(input idp_pkg::idp_req_t r, input logic [1:0] off);
    hit = (r.addr == off);
  endfunction

  // Bit 7 of the control word picks the direction of the output port.
  function automatic idp_pkg::idp_dir_t ctrl_dir(input logic [7:0] word);
    ctrl_dir = word[idp_pkg::CTRL_BIT_MODE] ? idp_pkg::IDP_DIR_OUT : idp_pkg::IDP_DIR_IN;
  endfunction

  always_comb
  begin
    out_d   = out_q;
    dir_a_d = dir_a_q;
    dir_b_d = dir_b_q;
    rdata_d = idp_pkg::RD_ZERO;
    if (sync_clr)
    begin
      out_d   = idp_pkg::OUT_RESET;     // see R13
      dir_a_d = idp_pkg::IDP_DIR_IN;
      dir_b_d = idp_pkg::IDP_DIR_IN;
    end
    else
    begin
      if (host_req.wr && hit(host_req, idp_pkg::OFF_DIR_CTRL))
      begin
        // Any control write clears the output latch, like the original port chip.
        out_d   = idp_pkg::OUT_RESET;   // see R9
        dir_a_d = ctrl_dir(host_req.wdata); // see R4
        dir_b_d = idp_pkg::IDP_DIR_IN;  // see R4
      end
      else if (host_req.wr && hit(host_req, idp_pkg::OFF_OUT_DATA))
        out_d = host_req.wdata;         // see R1
      // Writes to the input register fall through untouched. see R14
      if (host_req.rd)
      begin
        if (hit(host_req, idp_pkg::OFF_OUT_DATA))
          rdata_d = line_q;             // see R2
        else if (hit(host_req, idp_pkg::OFF_IN_DATA))
          rdata_d = in_sync_q;          // see R3 R8
        else
          rdata_d = idp_pkg::RD_ZERO;   // see R14
      end
    end
    oe_d   = (dir_a_d == idp_pkg::IDP_DIR_OUT);
    line_d = oe_d ? out_d : 8'h00;      // see R7
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q   <= idp_pkg::OUT_RESET;
      dir_a_q <= idp_pkg::IDP_DIR_IN;   // see R12
      dir_b_q <= idp_pkg::IDP_DIR_IN;
      rdata_q <= idp_pkg::RD_ZERO;
      line_q  <= 8'h00;
      oe_q    <= 1'b0;
    end
    else
    begin
      out_q   <= out_d;
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
      rdata_q <= rdata_d;
      line_q  <= line_d;
      oe_q    <= oe_d;
    end
  end

  assign host_rdata           = rdata_q;
  assign isolated_output_line = line_q;
  assign output_enable        = oe_q;

  // ==========================================================================
  // Interrupt request
  // ==========================================================================
  // The port has no interrupt source; the pin is a flop so it never glitches.
  logic irq_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= 1'b0;                    // see R11
  end
  assign host_irq = irq_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_out_write_latch: assert property ( // see R1
    host_req.wr && !sync_clr && host_req.addr == idp_pkg::OFF_OUT_DATA
    |=> out_q == $past(host_req.wdata))
    else $error("output latch missed write");

  a_out_readback: assert property ( // see R2
    host_req.rd && !sync_clr && host_req.addr == idp_pkg::OFF_OUT_DATA
    |=> host_rdata == $past(isolated_output_line))
    else $error("output readback wrong");

  a_in_read_value: assert property ( // see R3
    host_req.rd && !sync_clr && host_req.addr == idp_pkg::OFF_IN_DATA
    |=> host_rdata == $past(in_sync_q))
    else $error("input read wrong");

  a_in_pin_path: assert property ( // see R8
    ##2 in_sync_q == $past(isolated_input_line, 2))
    else $error("input sync path wrong");

  a_ctrl_sets_dir: assert property ( // see R4
    host_req.wr && !sync_clr && host_req.addr == idp_pkg::OFF_DIR_CTRL
    && host_req.wdata[idp_pkg::CTRL_BIT_MODE]
    |=> output_enable && dir_b_q == idp_pkg::IDP_DIR_IN)
    else $error("control write did not set direction");

  a_ctrl_clears_out: assert property ( // see R9
    host_req.wr && !sync_clr && host_req.addr == idp_pkg::OFF_DIR_CTRL
    |=> isolated_output_line == 8'h00)
    else $error("control write kept output data");

  a_lines_follow: assert property ( // see R7
    output_enable |-> isolated_output_line == out_q)
    else $error("output lines differ from latch");

  a_no_irq: assert property (!host_irq) // see R11
    else $error("interrupt raised");

  a_sync_reset: assert property ( // see R13
    sync_clr |=> out_q == 8'h00 && !output_enable)
    else $error("sync reset incomplete");

  a_ctrl_read_zero: assert property ( // see R14
    host_req.rd && !sync_clr && host_req.addr == idp_pkg::OFF_DIR_CTRL
    |=> host_rdata == 8'h00)
    else $error("control read not zero");

  // A control read must leave the latch and the direction alone.
  a_ctrl_read_clean: assert property ( // see R14
    host_req.rd && !host_req.wr && !sync_clr && host_req.addr == idp_pkg::OFF_DIR_CTRL
    |=> $stable(out_q) && $stable(output_enable))
    else $error("control read had a side effect");

  a_off2_read_zero: assert property ( // see R14
    host_req.rd && !sync_clr && host_req.addr == 2'h2
    |=> host_rdata == 8'h00)
    else $error("unused offset read not zero");

  a_in_write_ignored: assert property ( // see R14
    host_req.wr && !sync_clr && host_req.addr == idp_pkg::OFF_IN_DATA
    |=> $stable(out_q) && $stable(output_enable))
    else $error("input register write had an effect");

  a_rdata_idle_zero: assert property ( // see R14
    !host_req.rd |=> host_rdata == 8'h00)
    else $error("read data not zero while idle");

  a_out_hold_idle: assert property ( // see R1
    !sync_clr && !(host_req.wr && (host_req.addr == idp_pkg::OFF_OUT_DATA
    || host_req.addr == idp_pkg::OFF_DIR_CTRL)) |=> $stable(out_q))
    else $error("output latch changed without a write");

  a_lines_after_data: assert property ( // see R7
    host_req.wr && !sync_clr && output_enable && host_req.addr == idp_pkg::OFF_OUT_DATA
    |=> isolated_output_line == $past(host_req.wdata))
    else $error("output lines missed written data");

  a_lines_zero_input: assert property ( // see R12
    !output_enable |-> isolated_output_line == 8'h00)
    else $error("output lines driven while input");

  a_in_read_pins: assert property ( // see R8
    host_req.rd && !sync_clr && host_req.addr == idp_pkg::OFF_IN_DATA
    |=> host_rdata == $past(isolated_input_line, 3))
    else $error("input read does not follow pins");

  a_port_b_input: assert property ( // see R4
    dir_b_q == idp_pkg::IDP_DIR_IN)
    else $error("input port left input direction");

  a_ctrl_bit7_clear: assert property ( // see R4
    host_req.wr && !sync_clr && host_req.addr == idp_pkg::OFF_DIR_CTRL
    && !host_req.wdata[idp_pkg::CTRL_BIT_MODE] |=> !output_enable)
    else $error("control word without bit 7 set output");

  a_oe_hold: assert property ( // see R4
    !sync_clr && !(host_req.wr && host_req.addr == idp_pkg::OFF_DIR_CTRL)
    |=> $stable(output_enable))
    else $error("direction changed without control write");

  // Reset leaves both ports input and the read bus quiet.
  a_reset_start_input: assert property ( // see R12
    $rose(rst_b) |-> !output_enable && host_rdata == 8'h00)
    else $error("ports not input after reset");

  a_sync_beats_write: assert property ( // see R13
    sync_clr && host_req.wr |=> out_q == idp_pkg::OUT_RESET)
    else $error("write won over synchronous clear");

  a_sync_rdata_zero: assert property ( // see R13
    sync_clr |=> host_rdata == 8'h00)
    else $error("read served during synchronous clear");

  c_ctrl_then_write: cover property (
    host_req.wr && host_req.addr == idp_pkg::OFF_DIR_CTRL
    ##[1:20] host_req.wr && host_req.addr == idp_pkg::OFF_OUT_DATA);
  c_input_read_one: cover property (
    host_req.rd && host_req.addr == idp_pkg::OFF_IN_DATA ##1 host_rdata != 8'h00);
  c_sync_clear: cover property (output_enable ##1 sync_clr);
  c_in_write: cover property (
    host_req.wr && host_req.addr == idp_pkg::OFF_IN_DATA && output_enable);

endmodule

`default_nettype wire

// ===== testbench/idp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ======
// Host side of the register bus.
module idp_host_model (
  input  wire logic         ref_clk,    // Bus clock.
  output var idp_pkg::idp_req_t host_req, // Strobes toward the port.
  input  wire logic [7:0]   host_rdata  // Read answer.
);
  initial host_req = '0;

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    host_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    host_req <= '0;
    #1;
    d = host_rdata;
  endtask

  // The standard word keeps every fixed control bit as required.
  task automatic cfg();
    wr(idp_pkg::OFF_DIR_CTRL, idp_pkg::CTRL_WORD_STD);
  endtask
endmodule

`default_nettype wire

// ===== testbench/idp_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module idp_port_tb_top;
  logic              ref_clk  = 1'b0;
  logic              rst_b    = 1'b0;
  logic              sync_clr = 1'b0;
  logic [7:0]        in_lines = 8'h00;
  idp_pkg::idp_req_t req;
  logic [7:0]        rdata, lines, got, v;
  logic              oe, irq;
  logic [31:0]       lfsr = 32'h00010245;
  int                err_total = 0;
  int                checks_done = 0;

  always #20 ref_clk = ~ref_clk;

  idp_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .sync_clr(sync_clr), .host_req(req),
    .host_rdata(rdata), .isolated_output_line(lines), .output_enable(oe),
    .isolated_input_line(in_lines), .host_irq(irq));
  idp_host_model host (.ref_clk(ref_clk), .host_req(req), .host_rdata(rdata));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      err_total++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end

  // ======
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    host.rd(idp_pkg::OFF_OUT_DATA, got);
    chk(got, 8'h00);
    @(posedge ref_clk);
    chk({7'h00, oe}, 8'h00);
    chk(lines, 8'h00);
    host.cfg();
    chk({7'h00, oe}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      lfsr = step(lfsr);
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : lfsr[7:0];
      host.wr(idp_pkg::OFF_OUT_DATA, v);
      chk(lines, v);
      host.rd(idp_pkg::OFF_OUT_DATA, got);
      chk(got, v);
      @(posedge ref_clk);
      in_lines <= lfsr[15:8];
      // Three edges cover the two-flop synchroniser before the read.
      repeat (3) @(posedge ref_clk);
      host.rd(idp_pkg::OFF_IN_DATA, got);
      chk(got, lfsr[15:8]);
    end
    host.wr(idp_pkg::OFF_IN_DATA, 8'hFF);
    chk(lines, v);
    host.rd(idp_pkg::OFF_DIR_CTRL, got);
    chk(got, 8'h00);
    host.cfg();
    chk(lines, 8'h00);
    @(posedge ref_clk);
    in_lines <= 8'h00;
    repeat (3) @(posedge ref_clk);
    host.rd(idp_pkg::OFF_IN_DATA, got);
    chk(got, 8'h00);
    host.wr(idp_pkg::OFF_OUT_DATA, 8'hFF);
    @(posedge ref_clk);
    sync_clr <= 1'b1;
    @(posedge ref_clk);
    sync_clr <= 1'b0;
    #1;
    chk(lines, 8'h00);
    chk({7'h00, oe}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire
